// ### hdl/frl_divider.sv
// Serial restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module frl_divider import frl_pkg::*; #(
  parameter int N = 32
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request
  input wire logic start,
  input wire logic [N-1:0] dividend,
  input wire logic [N-1:0] divisor,
  // Answer
  output logic [N-1:0] quotient,
  output logic done
);
  logic [N-1:0] rem;
  logic [N-1:0] quo;
  logic [N-1:0] dsr;
  logic [5:0] cnt;
  logic busy;
  logic [N:0] trial;

  assign trial = {rem, quo[N-1]} - {1'b0, dsr};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rem <= '0;
      quo <= '0;
      dsr <= '0;
      cnt <= 6'h00;
      busy <= 1'b0;
      done <= 1'b0;
      quotient <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rem <= '0;
        quo <= dividend;
        dsr <= divisor;
        cnt <= 6'(N);
        busy <= 1'b1;
      end else if (busy) begin
        if (!trial[N]) begin
          rem <= trial[N-1:0];
          quo <= {quo[N-2:0], 1'b1};
        end else begin
          rem <= {rem[N-2:0], quo[N-1]};
          quo <= {quo[N-2:0], 1'b0};
        end
        cnt <= cnt - 6'h01;
        if (cnt == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          quotient <= !trial[N] ? {quo[N-2:0], 1'b1} : {quo[N-2:0], 1'b0};
        end
      end
    end
  end
endmodule : frl_divider

// ### hdl/frl_limiter.sv
// Frequency command limiter, ramp generator and voltage shaper with AHB-Lite registers
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "frl_params.svh"
module frl_limiter import frl_pkg::*; (
  // Bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Reference terminals
  input wire logic [11:0] voltage_ref_input,
  input wire logic [11:0] current_ref_input,
  input wire logic signed [11:0] bipolar_ref_input,
  input wire logic forward_run_terminal,
  input wire logic reverse_run_terminal,
  // Power stage command
  output logic [15:0] out_freq,
  output logic out_reverse,
  output logic [15:0] out_voltage,
  output logic out_active
);
  frl_motor_set_type set1, set2, act;
  frl_addr_phase_type aph;
  frl_freq_type base_freq_setting, start_freq_setting, keypad_freq, motor_voltage;
  logic [31:0] ctrl;
  logic [2:0] freq_source_select, run_source_select;
  logic direction_select;

  function automatic frl_freq_type fit_freq(input logic [31:0] v, input frl_freq_type lo);
    frl_freq_type f;
    f = (v > 32'(`FRL_FREQ_TOP)) ? `FRL_FREQ_TOP : v[15:0];
    if (f < lo)
      f = lo;
    if (f >= `FRL_FREQ_FINE)
      f = f - 16'(f % 16'h000A);
    return f;
  endfunction : fit_freq

  function automatic frl_freq_type fit_limit(input logic [31:0] v);
    return (v == 32'h0) ? `FRL_LIMIT_RST : fit_freq(v, 16'h0001);
  endfunction : fit_limit

  function automatic frl_time_type fit_time(input logic [31:0] v);
    frl_time_type t;
    t = (v > 32'(`FRL_TIME_TOP)) ? `FRL_TIME_TOP : v[19:0];
    if (t < `FRL_TIME_MIN)
      t = `FRL_TIME_MIN;
    if (t >= `FRL_TIME_COARSE)
      t = t - 20'(t % 20'h00064);
    else if (t >= `FRL_TIME_MID)
      t = t - 20'(t % 20'h0000A);
    return t;
  endfunction : fit_time

  // Bus address phase; zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      aph.valid <= hsel && htrans[1] && hready;
      aph.write <= hwrite;
      aph.addr <= haddr;
    end
  end

  // Frequency and time writes clip into the legal range and resolution
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      set1 <= '{`FRL_MAX_RST, `FRL_LIMIT_RST, `FRL_LIMIT_RST, `FRL_TIME_RST, `FRL_TIME_RST};
      set2 <= '{`FRL_MAX_RST, `FRL_LIMIT_RST, `FRL_LIMIT_RST, `FRL_TIME_RST, `FRL_TIME_RST};
      base_freq_setting <= `FRL_BASE_RST;
      start_freq_setting <= `FRL_START_RST;
      ctrl <= `FRL_CTRL_RST;
      keypad_freq <= `FRL_LIMIT_RST;
      motor_voltage <= `FRL_VMOT_RST;
    end else if (aph.valid && aph.write) begin
      unique case (aph.addr)
        `FRL_OFS_M1: set1.max_freq <= fit_freq(hwdata, `FRL_MAX_MIN);
        `FRL_OFS_M1 + 8'h04: set1.upper <= fit_limit(hwdata);
        `FRL_OFS_M1 + 8'h08: set1.lower <= fit_limit(hwdata);
        `FRL_OFS_M1 + 8'h0C: set1.accel <= fit_time(hwdata);
        `FRL_OFS_M1 + 8'h10: set1.decel <= fit_time(hwdata);
        `FRL_OFS_M2: set2.max_freq <= fit_freq(hwdata, `FRL_MAX_MIN);
        `FRL_OFS_M2 + 8'h04: set2.upper <= fit_limit(hwdata);
        `FRL_OFS_M2 + 8'h08: set2.lower <= fit_limit(hwdata);
        `FRL_OFS_M2 + 8'h0C: set2.accel <= fit_time(hwdata);
        `FRL_OFS_M2 + 8'h10: set2.decel <= fit_time(hwdata);
        `FRL_OFS_BASE: base_freq_setting <= fit_freq(hwdata, `FRL_MAX_MIN);
        `FRL_OFS_START: start_freq_setting <= (hwdata > 32'(`FRL_START_TOP)) ? `FRL_START_TOP :
          (hwdata < 32'(`FRL_START_MIN)) ? `FRL_START_MIN : hwdata[15:0];
        `FRL_OFS_CTRL: ctrl <= hwdata;
        `FRL_OFS_KEYPAD: keypad_freq <= fit_freq(hwdata, 16'h0000);
        `FRL_OFS_VMOT: motor_voltage <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read data registered in the address phase; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr)
        `FRL_OFS_M1: hrdata <= {16'h0, set1.max_freq};
        `FRL_OFS_M1 + 8'h04: hrdata <= {16'h0, set1.upper};
        `FRL_OFS_M1 + 8'h08: hrdata <= {16'h0, set1.lower};
        `FRL_OFS_M1 + 8'h0C: hrdata <= {12'h0, set1.accel};
        `FRL_OFS_M1 + 8'h10: hrdata <= {12'h0, set1.decel};
        `FRL_OFS_M2: hrdata <= {16'h0, set2.max_freq};
        `FRL_OFS_M2 + 8'h04: hrdata <= {16'h0, set2.upper};
        `FRL_OFS_M2 + 8'h08: hrdata <= {16'h0, set2.lower};
        `FRL_OFS_M2 + 8'h0C: hrdata <= {12'h0, set2.accel};
        `FRL_OFS_M2 + 8'h10: hrdata <= {12'h0, set2.decel};
        `FRL_OFS_BASE: hrdata <= {16'h0, base_freq_setting};
        `FRL_OFS_START: hrdata <= {16'h0, start_freq_setting};
        `FRL_OFS_CTRL: hrdata <= ctrl;
        `FRL_OFS_KEYPAD: hrdata <= {16'h0, keypad_freq};
        `FRL_OFS_VMOT: hrdata <= {16'h0, motor_voltage};
        `FRL_OFS_STAT_FREQ: hrdata <= {out_active, 14'h0, out_reverse, out_freq};
        `FRL_OFS_STAT_OUT: hrdata <= {16'h0, out_voltage};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Command path
  assign direction_select = ctrl[`FRL_DIR_BIT];
  assign freq_source_select = ctrl[`FRL_FSRC_LSB +: 3];
  assign run_source_select = ctrl[`FRL_RSRC_LSB +: 3];
  assign act = ctrl[`FRL_MOTOR2_BIT] ? set2 : set1;

  logic from_terms, run_req, want_rev, bip_neg;
  logic [11:0] uni_ref, bip_mag, ref_code;
  logic [27:0] scaled;
  frl_freq_type cmd, clamped, target, eff_target;

  assign from_terms = freq_source_select == `FRL_FSRC_TERM;
  assign uni_ref = (voltage_ref_input > current_ref_input) ? voltage_ref_input :
    current_ref_input;
  assign bip_neg = bipolar_ref_input[11];
  assign bip_mag = bip_neg ? 12'(-bipolar_ref_input) : bipolar_ref_input;
  assign ref_code = (bip_mag > uni_ref) ? bip_mag : uni_ref;
  assign scaled = 28'(ref_code * act.max_freq);
  // Full-scale code lands exactly on the maximum
  assign cmd = !from_terms ? ((keypad_freq > act.max_freq) ? act.max_freq : keypad_freq) :
    (ref_code == `FRL_REF_FULL) ? act.max_freq : scaled[27:12];

  // FW and REVERSE_RUN_TERMINAL together mean stop
  always_comb begin
    if (run_source_select == `FRL_RSRC_TERM) begin
      run_req = forward_run_terminal ^ reverse_run_terminal;
      want_rev = reverse_run_terminal;
    end else begin
      run_req = ctrl[`FRL_KRUN_BIT];
      want_rev = direction_select;
    end
    if (from_terms && bip_neg && bip_mag >= uni_ref)
      want_rev = !want_rev;
  end

  always_comb begin
    clamped = cmd;
    if (act.upper != 16'h0 && clamped > act.upper)
      clamped = act.upper;
    if (act.lower != 16'h0 && clamped < act.lower)
      clamped = act.lower;
    if (clamped > act.max_freq)
      clamped = act.max_freq;
    target = (!run_req || clamped < start_freq_setting) ? 16'h0000 : clamped;
  end

  // Reversal first ramps down through zero
  assign eff_target = (want_rev != out_reverse) ? 16'h0000 : target;

  // Bresenham ramp: one count of 0.01 Hz per overflow
  logic [39:0] acc, thr, sum;
  logic ramp_up;
  assign ramp_up = out_freq < eff_target;
  assign thr = 40'((ramp_up ? act.accel : act.decel) * `FRL_CYC_PER_UNIT);
  assign sum = acc + 40'(act.max_freq);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_freq <= 16'h0000;
      acc <= 40'h0;
    end else if (out_freq > act.max_freq) begin
      out_freq <= act.max_freq;
      acc <= 40'h0;
    end else if (out_freq == eff_target) begin
      acc <= 40'h0;
    end else if (sum >= thr) begin
      acc <= sum - thr;
      out_freq <= ramp_up ? out_freq + 16'h0001 : out_freq - 16'h0001;
    end else begin
      acc <= sum;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_reverse <= 1'b0;
      out_active <= 1'b0;
    end else begin
      if (out_freq == 16'h0000)
        out_reverse <= want_rev;
      out_active <= eff_target != 16'h0000 || out_freq != 16'h0000;
    end
  end

  // Voltage shaping; one division per 34 cycles is ample for a ramp
  frl_volt_state_type vstate;
  frl_freq_type vf;
  logic div_start, div_done;
  logic [31:0] quot;

  assign div_start = vstate == V_IDLE;

  frl_divider #(.N(32)) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(div_start),
    .dividend(32'(motor_voltage * out_freq)),
    .divisor({16'h0, base_freq_setting}),
    .quotient(quot),
    .done(div_done)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vstate <= V_IDLE;
      vf <= 16'h0000;
      out_voltage <= 16'h0000;
    end else begin
      unique case (vstate)
        V_IDLE: begin
          vf <= out_freq;
          vstate <= V_DIV;
        end
        V_DIV: begin
          if (div_done) begin
            vstate <= V_IDLE;
            out_voltage <= (vf >= base_freq_setting) ? motor_voltage : quot[15:0];
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_freq_max_cap: assert property ($past(out_freq) <= $past(act.max_freq) |->
    out_freq <= act.max_freq) else $error("output above max");
  a_max_range: assert property (act.max_freq >= `FRL_MAX_MIN &&
    act.max_freq <= `FRL_FREQ_TOP) else $error("max out of range");
  a_start_gate: assert property (target == 16'h0 || target >= start_freq_setting)
    else $error("target below start");
  a_upper_clamp: assert property (act.upper != 16'h0 |-> target <= act.upper)
    else $error("upper not applied");
  a_lower_hold: assert property (run_req && act.lower >= start_freq_setting &&
    act.lower != 16'h0 |-> target >= act.lower) else $error("lower not held");
  a_ramp_step: assert property (out_freq != $past(out_freq) && $past(out_freq) <=
    $past(act.max_freq) |-> out_freq == $past(out_freq) + 16'h1 ||
    out_freq == $past(out_freq) - 16'h1) else $error("ramp jumped");
  a_ramp_settle: assert property (out_freq == eff_target && $stable(eff_target) |=>
    out_freq == $past(eff_target)) else $error("ramp left target");
  a_volt_flat: assert property (vstate == V_DIV && div_done && vf >= base_freq_setting
    |=> out_voltage == $past(motor_voltage)) else $error("flat voltage wrong");
  a_dir_keypad: assert property (run_source_select != `FRL_RSRC_TERM && !from_terms
    |-> want_rev == direction_select) else $error("keypad direction wrong");
endmodule : frl_limiter

// ### hdl/frl_params.svh
// Constants for the frequency reference ramp limiter
`ifndef FRL_PARAMS_SVH
`define FRL_PARAMS_SVH
`define FRL_CLK_HZ 25000000
`define FRL_TIME_UNIT_US 10000
`define FRL_CYC_PER_UNIT (`FRL_CLK_HZ / 1000000 * `FRL_TIME_UNIT_US)
`define FRL_OFS_M1 8'h00
`define FRL_OFS_M2 8'h14
`define FRL_OFS_BASE 8'h28
`define FRL_OFS_START 8'h2C
`define FRL_OFS_CTRL 8'h30
`define FRL_OFS_KEYPAD 8'h34
`define FRL_OFS_VMOT 8'h38
`define FRL_OFS_STAT_FREQ 8'h3C
`define FRL_OFS_STAT_OUT 8'h40
`define FRL_MAX_RST 16'h1770
`define FRL_BASE_RST 16'h1770
`define FRL_START_RST 16'h0032
`define FRL_LIMIT_RST 16'h0000
`define FRL_TIME_RST 20'h00BB8
`define FRL_VMOT_RST 16'h00E6
`define FRL_CTRL_RST 32'h0000_0200
`define FRL_MAX_MIN 16'h0BB8
`define FRL_FREQ_TOP 16'h9C40
`define FRL_FREQ_FINE 16'h2710
`define FRL_START_MIN 16'h000A
`define FRL_START_TOP 16'h03E8
`define FRL_TIME_MIN 20'h00001
`define FRL_TIME_MID 20'h003E8
`define FRL_TIME_COARSE 20'h186A0
`define FRL_TIME_TOP 20'h57E40
`define FRL_DIR_BIT 0
`define FRL_FSRC_LSB 4
`define FRL_RSRC_LSB 8
`define FRL_MOTOR2_BIT 12
`define FRL_KRUN_BIT 13
`define FRL_FSRC_TERM 3'h1
`define FRL_RSRC_TERM 3'h1
`define FRL_REF_FULL 12'hFFF
`endif

// ### hdl/frl_pkg.sv
// Types shared by the frequency reference ramp limiter
package frl_pkg;
  typedef logic [15:0] frl_freq_type;
  typedef logic [19:0] frl_time_type;
  typedef struct packed {
    frl_freq_type max_freq;
    frl_freq_type upper;
    frl_freq_type lower;
    frl_time_type accel;
    frl_time_type decel;
  } frl_motor_set_type;
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic valid;
  } frl_addr_phase_type;
  typedef enum logic {V_IDLE = 1'b0, V_DIV = 1'b1} frl_volt_state_type;
endpackage : frl_pkg

// ### verif/frl_limiter_bench.sv
// Self-checking bench for the frequency reference ramp limiter
`timescale 1ns/1ps
module frl_limiter_bench import frl_pkg::*;;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, out_reverse, out_active;
  logic set_fw, set_rev, fw_t, rev_t;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rv;
  logic [11:0] set_volt, set_cur, set_bip, v_ref, c_ref;
  logic signed [11:0] b_ref;
  logic [15:0] out_freq, out_voltage;
  int error_cnt = 0;
  int checked = 0;
  int ramp_n;
  localparam logic [7:0] RA [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20,
    8'h2C, 8'h30, 8'h44};
  localparam logic [31:0] RV [11] = '{32'h1770, 32'h0, 32'h0, 32'hBB8, 32'hBB8, 32'h1770,
    32'h0, 32'hBB8, 32'h32, 32'h200, 32'h0};
  localparam logic [7:0] CA [9] = '{8'h00, 8'h00, 8'h2C, 8'h2C, 8'h04, 8'h0C, 8'h0C, 8'h2C,
    8'h04};
  localparam logic [31:0] CW [9] = '{32'h10, 32'hC350, 32'h5, 32'h3E9, 32'h3039, 32'h186A1,
    32'h3E9, 32'h32, 32'h0};
  localparam logic [31:0] CV [9] = '{32'hBB8, 32'h9C40, 32'hA, 32'h3E8, 32'h3034, 32'h186A0,
    32'h3E8, 32'h32, 32'h0};

  always #20 hclk = ~hclk;

  frl_terminal_model u_terms (.set_volt(set_volt), .set_cur(set_cur), .set_bip(set_bip),
    .set_fw(set_fw), .set_rev(set_rev), .voltage_ref_input(v_ref),
    .current_ref_input(c_ref), .bipolar_ref_input(b_ref), .forward_run_terminal(fw_t),
    .reverse_run_terminal(rev_t));

  frl_limiter u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .voltage_ref_input(v_ref),
    .current_ref_input(c_ref), .bipolar_ref_input(b_ref), .forward_run_terminal(fw_t),
    .reverse_run_terminal(rev_t), .out_freq(out_freq), .out_reverse(out_reverse),
    .out_voltage(out_voltage), .out_active(out_active));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task complete_run;
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // Single word transfer; the single slave's hreadyout is the bus ready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rv, e);
  endtask : rd

  // Wait for the output to land, then let it sit to catch overshoot
  task settle(input logic [15:0] f, input int lim);
    ramp_n = 0;
    while (out_freq !== f && ramp_n < lim) begin
      @(posedge hclk);
      ramp_n++;
    end
    repeat (40) @(posedge hclk);
    check(32'(out_freq), 32'(f));
  endtask : settle

  initial begin
    hresetn <= 1'b0;
    hsel <= 1'b0;
    haddr <= 8'h00;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0;
    set_volt <= 12'h000;
    set_cur <= 12'h000;
    set_bip <= 12'h000;
    set_fw <= 1'b0;
    set_rev <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(32'({out_active, out_reverse, out_freq}), 32'h0);
    for (int i = 0; i < 11; i++) rd(RA[i], RV[i]);
    for (int i = 0; i < 9; i++) begin
      wr(CA[i], CW[i]);
      rd(CA[i], CV[i]);
    end
    wr(8'h00, 32'h9C40);
    wr(8'h0C, 32'h1);
    wr(8'h10, 32'h1);
    wr(8'h34, 32'h3E8);
    wr(8'h30, 32'h2200);
    settle(16'h03E8, 7000);
    check(32'(ramp_n > 6150 && ramp_n < 6350), 32'h1);
    rd(8'h40, 32'h26);
    wr(8'h28, 32'hBB8);
    wr(8'h34, 32'hFA0);
    settle(16'h0FA0, 19500);
    check(32'(out_voltage), 32'hE6);
    wr(8'h04, 32'h7D0);
    settle(16'h07D0, 13000);
    check(32'(out_voltage), 32'h99);
    wr(8'h08, 32'h5DC);
    wr(8'h30, 32'h2210);
    wr(8'h04, 32'h0);
    settle(16'h05DC, 3500);
    check(32'({out_reverse, out_voltage}), 32'h73);
    set_bip <= 12'hF80;
    // Reversal must pass through zero before the direction flips
    do @(posedge hclk); while (out_reverse !== 1'b1);
    check(32'(out_freq), 32'h0);
    settle(16'h05DC, 9800);
    rd(8'h3C, 32'h8001_05DC);
    wr(8'h34, 32'h5DC);
    wr(8'h30, 32'h2201);
    settle(16'h05DC, 100);
    check(32'(out_reverse), 32'h1);
    wr(8'h08, 32'h0);
    wr(8'h34, 32'h28);
    settle(16'h0000, 10000);
    check(32'(out_active), 32'h0);
    set_bip <= 12'h000;
    // Current loop is the larger reference, so it sets the command
    set_volt <= 12'h020;
    set_cur <= 12'h040;
    set_fw <= 1'b1;
    wr(8'h30, 32'h0110);
    settle(16'h0271, 5000);
    check(32'(out_reverse), 32'h0);
    set_rev <= 1'b1;
    settle(16'h0000, 5000);
    wr(8'h14, 32'h9C40);
    wr(8'h20, 32'h1);
    wr(8'h24, 32'h1);
    wr(8'h18, 32'h12C);
    set_rev <= 1'b0;
    set_volt <= 12'hFFF;
    wr(8'h30, 32'h1110);
    settle(16'h012C, 2500);
    complete_run();
  end

  initial begin
    repeat (90000) @(posedge hclk);
    error_cnt++;
    complete_run();
  end
endmodule : frl_limiter_bench

// ### verif/frl_terminal_model.sv
// Far-side model: analog reference terminals and run switches
`timescale 1ns/1ps
module frl_terminal_model (
  // Settings from the bench
  input wire logic [11:0] set_volt,
  input wire logic [11:0] set_cur,
  input wire logic [11:0] set_bip,
  input wire logic set_fw,
  input wire logic set_rev,
  // Terminal lines
  output logic [11:0] voltage_ref_input,
  output logic [11:0] current_ref_input,
  output logic signed [11:0] bipolar_ref_input,
  output logic forward_run_terminal,
  output logic reverse_run_terminal
);
  // Levels only, no framing: the lines always carry a defined value
  assign voltage_ref_input = set_volt;
  // Code zero stands for the 4 mA floor
  assign current_ref_input = set_cur;
  // Two's complement, negative codes ask for reverse
  assign bipolar_ref_input = set_bip;
  // Both switches closed means stop
  assign forward_run_terminal = set_fw;
  assign reverse_run_terminal = set_rev;
endmodule : frl_terminal_model
